// ===== hdl/ddo_defines.vh
// constants for the ddr output cell and read polarity logic
// assumes inclusion by bare name from the design files
`ifndef DDO_DEFINES_VH
`define DDO_DEFINES_VH

// apb byte offsets
`define DDO_OFS_CTRL 8'h00
`define DDO_OFS_TXDATA 8'h04
`define DDO_OFS_RDCMD 8'h08
`define DDO_OFS_STATUS 8'h0C
`define DDO_OFS_RDDATA 8'h10
`define DDO_OFS_DELAY 8'h14

// control register fields
`define DDO_CTRL_SDR 0
`define DDO_CTRL_LATCH 1
`define DDO_CTRL_GEARBOX 2
`define DDO_CTRL_PADOE 3
`define DDO_CTRL_RST 4'h1

// read command fields
`define DDO_RDCMD_ARM 0
`define DDO_RDCMD_END 1

// status register fields
`define DDO_ST_POL 0
`define DDO_ST_ARMED 1
`define DDO_ST_PREAMBLE 2
`define DDO_ST_NOTEMPTY 3
`define DDO_ST_FULL 4

// output word layout
`define DDO_W_NEG 0
`define DDO_W_POS 1
`define DDO_W_A1 2
`define DDO_W_B1 3
`define DDO_WORD_W 4
`define DDO_FIFO_DEPTH 16
`define DDO_FIFO_AW 4

// transfer delay: percent of the measured edge clock period
`define DDO_DELAY_PCT 16'd90
`define DDO_PCT_FULL 16'd100
`define DDO_PERIOD_MAX 8'hFF

`endif

// ===== hdl/ddo_fifo.v
// fifo with registered read data for the output word stream
// assumes a single clock and an active low asynchronous reset
`timescale 1ns/1ps
`default_nettype none

module ddo_fifo #(
  parameter WIDTH = 4,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  input wire clk, // clock
  input wire rst_n, // async reset, active low
  input wire in_valid, // write request
  input wire [WIDTH-1:0] in_data, // write data
  output wire in_ready, // space available
  output wire out_valid, // head word present
  output wire [WIDTH-1:0] out_data, // head word
  input wire out_ready // head word taken
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_ff;
  reg [AW-1:0] rd_ptr_ff;
  reg [AW:0] cnt_ff;
  reg out_valid_ff;
  reg [WIDTH-1:0] out_data_ff;
  wire [31:0] cnt_wide = {{(31-AW){1'b0}}, cnt_ff};
  wire full = (cnt_wide == DEPTH);
  wire push = in_valid & ~full;
  wire load = (cnt_ff != {(AW+1){1'b0}}) & (~out_valid_ff | out_ready);

  assign in_ready = ~full;
  assign out_valid = out_valid_ff;
  assign out_data = out_data_ff;

  always @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_ff] <= in_data;
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_ff <= {AW{1'b0}};
      rd_ptr_ff <= {AW{1'b0}};
      cnt_ff <= {(AW+1){1'b0}};
      out_valid_ff <= 1'b0;
      out_data_ff <= {WIDTH{1'b0}};
    end else begin
      if (push) begin
        wr_ptr_ff <= wr_ptr_ff + 1'b1;
      end
      if (load) begin
        rd_ptr_ff <= rd_ptr_ff + 1'b1;
        out_data_ff <= mem[rd_ptr_ff];
        out_valid_ff <= 1'b1;
      end else if (out_ready) begin
        out_valid_ff <= 1'b0;
      end
      if (push & ~load) begin
        cnt_ff <= cnt_ff + 1'b1;
      end else if (load & ~push) begin
        cnt_ff <= cnt_ff - 1'b1;
      end
    end
  end

endmodule // ddo_fifo

`default_nettype wire

// ===== hdl/ddo_io_cell.v
// ddr/sdr output cell with read strobe polarity control, apb registers
// assumes pclk at 10 MHz; edge clock, strobe and read data are async pins
//
// Summary of operation
// - single rate: negative-phase data passes one storage element to the pad
// - single rate storage element works as flip-flop or as level latch
// - double rate: both phases are registered on edge clock rising edge
// - double rate: registered positive phase is latched in following phase
// - a mux on the same clock alternates the stored phases onto the pad
// - each output cell has single rate registers plus the extra ddr latch
// - gearbox mode serialises four parallel streams onto the pad
// - a polarity signal picks the clock edge for strobe-to-system transfer
// - the polarity does not change the strobe edges that capture read data
// - polarity is evaluated anew at the start of every read cycle
// - detection of strobe high-to-low at preamble sets the polarity
// - shared delay shifts the edge clock by 90 percent of its period
`include "ddo_defines.vh"
`timescale 1ns/1ps
`default_nettype none

module ddo_io_cell (
  input wire pclk, // system clock
  input wire presetn, // async reset, active low
  input wire psel, // apb select
  input wire penable, // apb enable
  input wire pwrite, // apb direction
  input wire [7:0] paddr, // apb byte address
  input wire [31:0] pwdata, // apb write data
  output wire [31:0] prdata, // apb read data
  output wire pready, // apb ready
  output wire pslverr, // apb error, unmapped address
  input wire edge_clock_first, // edge clock pin
  input wire strobe_in, // read strobe pin level
  input wire read_data_in, // read data pin
  output wire pad_output_data, // pad output
  output wire pad_output_enable, // pad driver enable
  output wire sync_clock_polarity_select, // read transfer polarity
  output wire strobe_transfer_delay // delayed edge clock
);

  // synchronisers
  reg [1:0] eclk_sync_ff;
  reg [1:0] stb_sync_ff;
  reg [1:0] dq_sync_ff;
  reg eclk_prev_ff;
  reg stb_prev_ff;
  wire eclk_s = eclk_sync_ff[1];
  wire stb_s = stb_sync_ff[1];
  wire dq_s = dq_sync_ff[1];
  wire eclk_rise = eclk_s & ~eclk_prev_ff;
  wire eclk_fall = ~eclk_s & eclk_prev_ff;
  wire stb_rise = stb_s & ~stb_prev_ff;
  wire stb_fall = ~stb_s & stb_prev_ff;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      eclk_sync_ff <= 2'h0;
      stb_sync_ff <= 2'h3;
      dq_sync_ff <= 2'h0;
      eclk_prev_ff <= 1'b0;
      stb_prev_ff <= 1'b1;
    end else begin
      eclk_sync_ff <= {eclk_sync_ff[0], edge_clock_first};
      stb_sync_ff <= {stb_sync_ff[0], strobe_in};
      dq_sync_ff <= {dq_sync_ff[0], read_data_in};
      eclk_prev_ff <= eclk_s;
      stb_prev_ff <= stb_s;
    end
  end

  // apb slave
  reg [3:0] ctrl_ff;
  reg pready_ff;
  reg pslverr_ff;
  reg [31:0] prdata_ff;
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire [`DDO_WORD_W-1:0] fifo_out_data;
  wire sel_ctrl = (paddr == `DDO_OFS_CTRL);
  wire sel_tx = (paddr == `DDO_OFS_TXDATA);
  wire sel_rdcmd = (paddr == `DDO_OFS_RDCMD);
  wire sel_status = (paddr == `DDO_OFS_STATUS);
  wire sel_rddata = (paddr == `DDO_OFS_RDDATA);
  wire sel_delay = (paddr == `DDO_OFS_DELAY);
  wire mapped = sel_ctrl | sel_tx | sel_rdcmd | sel_status | sel_rddata |
                sel_delay;
  wire acc_done = psel & penable & pready_ff;
  wire wr_done = acc_done & pwrite & mapped;
  wire tx_push = wr_done & sel_tx;
  wire tx_stall = pwrite & sel_tx & ~fifo_in_ready;
  wire rd_arm = wr_done & sel_rdcmd & pwdata[`DDO_RDCMD_ARM];
  wire rd_end = wr_done & sel_rdcmd & pwdata[`DDO_RDCMD_END];
  wire mode_sdr = ctrl_ff[`DDO_CTRL_SDR];
  wire mode_latch = ctrl_ff[`DDO_CTRL_LATCH];
  wire mode_gb = ctrl_ff[`DDO_CTRL_GEARBOX];

  // read-side state, declared here for the read mux
  reg pol_ff;
  reg rd_armed_ff;
  reg preamble_ff;
  reg [7:0] rd_data_ff;
  reg [7:0] period_ff;
  reg [7:0] delay_tgt_ff;

  reg [31:0] nxt_prdata;
  always @* begin
    nxt_prdata = 32'h0000_0000;
    if (sel_ctrl) begin
      nxt_prdata[3:0] = ctrl_ff;
    end else if (sel_status) begin
      nxt_prdata[`DDO_ST_POL] = pol_ff;
      nxt_prdata[`DDO_ST_ARMED] = rd_armed_ff;
      nxt_prdata[`DDO_ST_PREAMBLE] = preamble_ff;
      nxt_prdata[`DDO_ST_NOTEMPTY] = fifo_out_valid;
      nxt_prdata[`DDO_ST_FULL] = ~fifo_in_ready;
    end else if (sel_rddata) begin
      nxt_prdata[7:0] = rd_data_ff;
    end else if (sel_delay) begin
      nxt_prdata[15:0] = {delay_tgt_ff, period_ff};
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= `DDO_CTRL_RST;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
    end else begin
      // ready is held back while a data write finds the fifo full
      if (psel & penable & ~pready_ff & ~tx_stall) begin
        pready_ff <= 1'b1;
        pslverr_ff <= ~mapped;
        prdata_ff <= pwrite ? 32'h0000_0000 : nxt_prdata;
      end else begin
        pready_ff <= 1'b0;
        pslverr_ff <= 1'b0;
      end
      if (wr_done & sel_ctrl) begin
        ctrl_ff <= pwdata[3:0];
      end
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;

  // output word fifo, drained at edge clock pace
  reg [1:0] gb_ph_ff;
  wire pop_edge = mode_gb ? (eclk_rise & (gb_ph_ff == 2'h0)) :
                  (mode_sdr & mode_latch) ? eclk_fall : eclk_rise;
  wire pop = pop_edge & fifo_out_valid;

  ddo_fifo #(
    .WIDTH(`DDO_WORD_W),
    .DEPTH(`DDO_FIFO_DEPTH),
    .AW(`DDO_FIFO_AW)
  ) u_fifo (
    .clk(pclk),
    .rst_n(presetn),
    .in_valid(tx_push),
    .in_data(pwdata[`DDO_WORD_W-1:0]),
    .in_ready(fifo_in_ready),
    .out_valid(fifo_out_valid),
    .out_data(fifo_out_data),
    .out_ready(pop)
  );

  // output register block, one set per cell
  reg neg_reg_ff;
  reg pos_reg_ff;
  reg pos_latch_ff;
  reg sdr_store_ff;
  reg [`DDO_WORD_W-1:0] gb_word_ff;
  reg pad_ff;
  reg pad_oe_ff;
  reg nxt_pad;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      neg_reg_ff <= 1'b0;
      pos_reg_ff <= 1'b0;
      pos_latch_ff <= 1'b0;
      sdr_store_ff <= 1'b0;
      gb_word_ff <= {`DDO_WORD_W{1'b0}};
      gb_ph_ff <= 2'h0;
      pad_ff <= 1'b0;
      pad_oe_ff <= 1'b0;
    end else begin
      if (mode_sdr & ~mode_latch & pop) begin
        sdr_store_ff <= fifo_out_data[`DDO_W_NEG];
      end else if (mode_sdr & mode_latch & eclk_s & fifo_out_valid) begin
        sdr_store_ff <= fifo_out_data[`DDO_W_NEG];
      end
      if (~mode_sdr & ~mode_gb & pop) begin
        neg_reg_ff <= fifo_out_data[`DDO_W_NEG];
        pos_reg_ff <= fifo_out_data[`DDO_W_POS];
      end
      if (~eclk_s) begin
        pos_latch_ff <= pos_reg_ff;
      end
      if (mode_gb & (eclk_rise | (eclk_fall & (gb_ph_ff != 2'h0)))) begin
        gb_ph_ff <= gb_ph_ff + 2'h1;
      end else if (~mode_gb) begin
        gb_ph_ff <= 2'h0;
      end
      if (pop & mode_gb) begin
        gb_word_ff <= fifo_out_data;
      end
      pad_ff <= nxt_pad;
      pad_oe_ff <= ctrl_ff[`DDO_CTRL_PADOE];
    end
  end

  always @* begin
    nxt_pad = pad_ff;
    if (mode_gb) begin
      case (gb_ph_ff)
        2'h1: nxt_pad = gb_word_ff[`DDO_W_NEG];
        2'h2: nxt_pad = gb_word_ff[`DDO_W_POS];
        2'h3: nxt_pad = gb_word_ff[`DDO_W_A1];
        2'h0: nxt_pad = gb_word_ff[`DDO_W_B1];
        default: nxt_pad = 1'b0;
      endcase
    end else if (mode_sdr) begin
      nxt_pad = sdr_store_ff;
    end else begin
      nxt_pad = eclk_s ? neg_reg_ff : pos_latch_ff;
    end
  end

  assign pad_output_data = pad_ff;
  assign pad_output_enable = pad_oe_ff;

  // shared transfer delay: measures the edge clock period and shifts it
  reg [7:0] period_cnt_ff;
  reg [7:0] dly_r_cnt_ff;
  reg [7:0] dly_f_cnt_ff;
  reg dly_clk_ff;
  reg dly_prev_ff;
  wire [15:0] dly_prod = {8'h00, period_ff} * `DDO_DELAY_PCT;
  wire [15:0] dly_quot = dly_prod / `DDO_PCT_FULL;
  wire [7:0] dly_calc = (dly_quot[7:0] == 8'h00) ? 8'h01 : dly_quot[7:0];

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      period_cnt_ff <= 8'h00;
      period_ff <= 8'h00;
      delay_tgt_ff <= 8'h01;
      dly_r_cnt_ff <= 8'h00;
      dly_f_cnt_ff <= 8'h00;
      dly_clk_ff <= 1'b0;
      dly_prev_ff <= 1'b0;
    end else begin
      dly_prev_ff <= dly_clk_ff;
      if (eclk_rise) begin
        period_cnt_ff <= 8'h01;
        period_ff <= period_cnt_ff;
      end else if (period_cnt_ff != `DDO_PERIOD_MAX) begin
        period_cnt_ff <= period_cnt_ff + 8'h01;
      end
      delay_tgt_ff <= dly_calc;
      if (eclk_rise) begin
        dly_r_cnt_ff <= 8'h01;
      end else if (dly_r_cnt_ff != 8'h00) begin
        if (dly_r_cnt_ff == delay_tgt_ff) begin
          dly_r_cnt_ff <= 8'h00;
          dly_clk_ff <= 1'b1;
        end else begin
          dly_r_cnt_ff <= dly_r_cnt_ff + 8'h01;
        end
      end
      if (eclk_fall) begin
        dly_f_cnt_ff <= 8'h01;
      end else if (dly_f_cnt_ff != 8'h00) begin
        if (dly_f_cnt_ff == delay_tgt_ff) begin
          dly_f_cnt_ff <= 8'h00;
          dly_clk_ff <= 1'b0;
        end else begin
          dly_f_cnt_ff <= dly_f_cnt_ff + 8'h01;
        end
      end
    end
  end

  assign strobe_transfer_delay = dly_clk_ff;

  // read side: preamble detection, polarity choice, data transfer
  reg cap_pos_ff;
  reg [1:0] pair_ff;
  reg pend_ff;
  // memory holds the strobe high by termination until the preamble
  wire preamble_evt = rd_armed_ff & stb_fall;
  wire dly_rise = dly_clk_ff & ~dly_prev_ff;
  wire dly_fall = ~dly_clk_ff & dly_prev_ff;
  wire xfer = pend_ff & (pol_ff ? dly_fall : dly_rise);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pol_ff <= 1'b0;
      rd_armed_ff <= 1'b0;
      preamble_ff <= 1'b0;
      cap_pos_ff <= 1'b0;
      pair_ff <= 2'h0;
      pend_ff <= 1'b0;
      rd_data_ff <= 8'h00;
    end else begin
      if (rd_arm) begin
        rd_armed_ff <= 1'b1;
      end else if (preamble_evt) begin
        rd_armed_ff <= 1'b0;
      end
      // the preamble event wins over a software end of read
      if (preamble_evt) begin
        preamble_ff <= 1'b1;
        pol_ff <= dly_clk_ff;
      end else if (rd_end | rd_arm) begin
        preamble_ff <= 1'b0;
      end
      if (preamble_ff & stb_rise) begin
        cap_pos_ff <= dq_s;
      end
      if (preamble_ff & stb_fall) begin
        pair_ff <= {cap_pos_ff, dq_s};
        pend_ff <= 1'b1;
      end else if (xfer | rd_arm | rd_end) begin
        pend_ff <= 1'b0;
      end
      if (xfer) begin
        rd_data_ff <= {rd_data_ff[5:0], pair_ff};
      end
    end
  end

  assign sync_clock_polarity_select = pol_ff;

endmodule // ddo_io_cell

`default_nettype wire

// ===== verification/ddo_mem_model.sv
// memory side of the read path: drives strobe and read data in bursts
// assumes the bench resolves an undriven strobe to the termination high
`timescale 1ns/1ps
`default_nettype none
module ddo_mem_model (
  input wire logic go, // rising edge starts one burst
  input wire logic slow, // long strobe half period
  input wire logic [7:0] burst, // {pos,neg} pairs, oldest in bits 7:6
  output logic strobe_oe, // strobe driven
  output logic strobe_o, // strobe level while driven
  output logic dq // read data pin
);
  int hp;
  initial begin
    strobe_oe = 1'b0;
    strobe_o = 1'b0;
    dq = 1'b0;
  end
  always @(posedge go) begin
    hp = slow ? 1200 : 400;
    strobe_oe = 1'b1;
    strobe_o = 1'b0;
    #(2 * hp);
    for (int i = 3; i >= 0; i--) begin
      dq = burst[2*i+1];
      #(hp / 2);
      strobe_o = 1'b1;
      #(hp / 2);
      dq = burst[2*i];
      #(hp / 2);
      strobe_o = 1'b0;
      #(hp / 2);
    end
    #hp;
    strobe_oe = 1'b0;
    // released data line no longer shows the last bit
    dq = ~dq;
  end
endmodule // ddo_mem_model
`default_nettype wire

// ===== verification/ddo_io_cell_props.sv
// port-level checks for the ddr output cell
// assumes pclk and presetn of the bound ddo_io_cell
`timescale 1ns/1ps
`default_nettype none
module ddo_io_cell_props (
  input wire logic pclk, // clock
  input wire logic presetn, // reset, active low
  input wire logic psel, // select
  input wire logic penable, // enable
  input wire logic pwrite, // direction
  input wire logic [7:0] paddr, // address
  input wire logic [31:0] prdata, // read data
  input wire logic pready, // ready
  input wire logic pslverr, // error
  input wire logic edge_clock_first, // edge clock pin
  input wire logic strobe_in, // strobe pin
  input wire logic pad_output_data, // pad
  input wire logic sync_clock_polarity_select, // polarity
  input wire logic strobe_transfer_delay // delayed clock
);
  logic ec_q_ff, stb_q_ff;
  logic [4:0] ec_age_ff, fall_age_ff;
  // cycles since the edge clock pin moved and since the strobe fell
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ec_q_ff <= 1'b0;
      stb_q_ff <= 1'b1;
      ec_age_ff <= 5'h1F;
      fall_age_ff <= 5'h1F;
    end else begin
      ec_q_ff <= edge_clock_first;
      stb_q_ff <= strobe_in;
      if (ec_q_ff != edge_clock_first)
        ec_age_ff <= 5'h00;
      else if (ec_age_ff != 5'h1F)
        ec_age_ff <= ec_age_ff + 5'h01;
      if (stb_q_ff && !strobe_in)
        fall_age_ff <= 5'h00;
      else if (fall_age_ff != 5'h1F)
        fall_age_ff <= fall_age_ff + 5'h01;
    end
  end
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable && !pready && !(pwrite && paddr == 8'h04);
  endsequence
  property p_answer;
    s_setup ##1 s_access |=> pready;
  endproperty
  a_answer: assert property (p_answer)
    else $error("apb answer not on second access cycle");
  property p_pulse;
    pready |=> !pready;
  endproperty
  a_pulse: assert property (p_pulse) else $error("pready longer than one");
  property p_in_access;
    pready |-> psel && penable;
  endproperty
  a_in_access: assert property (p_in_access) else $error("pready idle");
  property p_err_map;
    pready |-> pslverr == (paddr > 8'h14 || paddr[1:0] != 2'b00);
  endproperty
  a_err_map: assert property (p_err_map) else $error("pslverr wrong");
  property p_wr_zero;
    pready && pwrite |-> prdata == 32'h0;
  endproperty
  a_wr_zero: assert property (p_wr_zero) else $error("prdata on write");
  property p_pad_hold;
    $changed(pad_output_data) |-> ec_age_ff < 5'd12;
  endproperty
  a_pad_hold: assert property (p_pad_hold)
    else $error("pad moved without edge clock");
  property p_pol_hold;
    $changed(sync_clock_polarity_select) |-> fall_age_ff < 5'd8;
  endproperty
  a_pol_hold: assert property (p_pol_hold)
    else $error("polarity moved without preamble");
  property p_dly_hold;
    $changed(strobe_transfer_delay) |-> ec_age_ff < 5'd24;
  endproperty
  a_dly_hold: assert property (p_dly_hold)
    else $error("delayed clock moved alone");
endmodule // ddo_io_cell_props
bind ddo_io_cell ddo_io_cell_props u_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .edge_clock_first(edge_clock_first),
  .strobe_in(strobe_in), .pad_output_data(pad_output_data),
  .sync_clock_polarity_select(sync_clock_polarity_select),
  .strobe_transfer_delay(strobe_transfer_delay)
);
`default_nettype wire

// ===== verification/testbench.sv
// self-checking bench for the ddr output cell, apb side and read strobe
// assumes ddo_io_cell, ddo_mem_model and the bound checker
`timescale 1ns/1ps
`default_nettype none
`include "ddo_defines.vh"
module testbench;
  typedef struct {
    logic [3:0] ctrl;
    logic [3:0] word;
    logic [3:0] pat;
  } ddo_row_t;
  logic pclk, presetn, psel, penable, pwrite, ec, ec_run, go, slow;
  logic [7:0] paddr, bits;
  logic [31:0] pwdata, prdata, q;
  logic pready, pslverr, pad, oe, pol, dly, stb_oe, stb_o, dq, e, done;
  logic [3:0] s;
  int error_cnt, n_checks, cyc;
  localparam int EC_PER = 8;
  // ctrl, pushed word, pad pattern over four half cycles
  ddo_row_t rows [6] = '{'{4'h9, 4'h1, 4'hF}, '{4'h9, 4'hE, 4'h0},
    '{4'hB, 4'h1, 4'hF}, '{4'h8, 4'h1, 4'hA}, '{4'h8, 4'h3, 4'hF},
    '{4'hC, 4'h6, 4'h6}};
  ddo_io_cell u_ddo_io_cell (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .edge_clock_first(ec),
    .strobe_in(stb_oe ? stb_o : 1'b1), .read_data_in(dq),
    .pad_output_data(pad), .pad_output_enable(oe),
    .sync_clock_polarity_select(pol), .strobe_transfer_delay(dly)
  );
  ddo_mem_model u_ddo_mem_model (
    .go(go), .slow(slow), .burst(bits), .strobe_oe(stb_oe),
    .strobe_o(stb_o), .dq(dq)
  );
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  initial begin
    ec = 1'b0;
    #37;
    forever #400 if (ec_run) ec = ~ec;
  end
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      error_cnt++;
      final_report();
    end
  end
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    chk32({31'h0, got}, {31'h0, exp});
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk32(q, x);
  endtask
  function automatic logic rot_ok(input logic [3:0] v, input logic [3:0] p);
    logic [7:0] pp;
    pp = {p, p};
    rot_ok = 1'b0;
    for (int r = 0; r < 4; r++)
      if (v === pp[r +: 4])
        rot_ok = 1'b1;
  endfunction
  task automatic sample_pad();
    repeat (3) @(posedge ec);
    #650;
    for (int k = 3; k >= 0; k--) begin
      s[k] = pad;
      #400;
    end
  endtask
  task automatic burst(input logic sl, input int ph, input logic [7:0] b);
    @(posedge ec);
    #ph;
    slow = sl;
    bits = b;
    go = 1'b1;
    #(sl ? 14000 : 5000);
    go = 1'b0;
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    {psel, penable, pwrite, go, slow, done} = '0;
    paddr = '0;
    pwdata = '0;
    bits = '0;
    presetn = 1'b0;
    ec_run = 1'b1;
    cyc = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rd(`DDO_OFS_CTRL, 32'h1);
    rd(`DDO_OFS_STATUS, 32'h0);
    chk1(oe, 1'b0);
    rd(8'h18, 32'h0);
    chk1(e, 1'b1);
    repeat (6) @(posedge ec);
    rd(`DDO_OFS_DELAY,
       {16'h0, 8'(EC_PER * 90 / 100), 8'(EC_PER)});
    // delayed clock: high from 90 percent of a period plus sync delay
    @(posedge ec);
    #263;
    chk1(dly, 1'b1);
    #400;
    chk1(dly, 1'b0);
    $display("reset and register test done");
    foreach (rows[i]) begin
      wr(`DDO_OFS_CTRL, {28'h0, rows[i].ctrl});
      wr(`DDO_OFS_TXDATA, {28'h0, rows[i].word});
      sample_pad();
      chk1(rot_ok(s, rows[i].pat), 1'b1);
      chk1(oe, 1'b1);
    end
    $display("output mode table done");
    wr(`DDO_OFS_CTRL, 32'h8);
    ec_run = 1'b0;
    // one output stage plus sixteen buffer words before full
    repeat (16) wr(`DDO_OFS_TXDATA, 32'h5);
    rd(`DDO_OFS_STATUS, 32'h8);
    wr(`DDO_OFS_TXDATA, 32'h5);
    rd(`DDO_OFS_STATUS, 32'h18);
    fork
      begin
        wr(`DDO_OFS_TXDATA, 32'hA);
        done = 1'b1;
      end
    join_none
    repeat (30) @(posedge pclk);
    chk1(done, 1'b0);
    ec_run = 1'b1;
    wait (done === 1'b1);
    do apb(1'b0, `DDO_OFS_STATUS, 32'h0); while (q[3] !== 1'b0);
    sample_pad();
    chk1(rot_ok(s, 4'h5), 1'b1);
    $display("buffer fill and drain test done");
    wr(`DDO_OFS_RDCMD, 32'h1);
    rd(`DDO_OFS_STATUS, 32'h2);
    burst(1'b0, 100, 8'hB4);
    rd(`DDO_OFS_STATUS, 32'h5);
    chk1(pol, 1'b1);
    rd(`DDO_OFS_RDDATA, 32'hB4);
    wr(`DDO_OFS_RDCMD, 32'h1);
    burst(1'b1, 500, 8'h3C);
    rd(`DDO_OFS_STATUS, 32'h4);
    chk1(pol, 1'b0);
    rd(`DDO_OFS_RDDATA, 32'h3C);
    $display("read polarity test done");
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rd(`DDO_OFS_CTRL, 32'h1);
    rd(`DDO_OFS_STATUS, 32'h0);
    chk1(oe, 1'b0);
    $display("mid-run reset test done");
    final_report();
  end
endmodule // testbench
`default_nettype wire
